// ==== rtl/interrupt_activation_router.sv ====
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module interrupt_activation_router
  import activation_router_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [NUM_SRC-1:0] irq_src,
  output logic [NUM_CH-1:0] dma_req,
  output logic [NUM_SRC-1:0] blk_xfer_req,
  output logic [NUM_SRC-1:0] cpu_irq_req
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic sel_ok(input logic [SEL_W-1:0] sel);
    sel_ok = (sel < SEL_W'(NUM_SRC));
  endfunction

  function automatic logic ch_claims(input logic [MODE_W-1:0] mode);
    ch_claims = mode[MODE_KIND_HI_BIT] & ~mode[MODE_KIND_LO_BIT] &
                mode[MODE_ENABLE_BIT] & mode[MODE_CLAIM_BIT];
  endfunction

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic wr_en;
  logic [5:0] reg_idx;
  logic [31:0] wr_data;
  logic [31:0] rd_data;

  router_ahb_slave u_slave (
    .core_clk(core_clk),
    .nrst(nrst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .wr_en(wr_en),
    .reg_idx(reg_idx),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  wire in_en = (reg_idx >= IDX_EN_BASE) && (reg_idx < IDX_EN_BASE + IDX_SPAN5);
  wire in_sel = (reg_idx >= IDX_SEL_BASE) && (reg_idx < IDX_SEL_BASE + IDX_SPAN4);
  wire in_mode = (reg_idx >= IDX_MODE_BASE) && (reg_idx < IDX_MODE_BASE + IDX_SPAN4);
  wire in_claim = (reg_idx >= IDX_CLAIM_BASE) && (reg_idx < IDX_CLAIM_BASE + IDX_SPAN5);
  wire [2:0] sub5 = reg_idx[2:0];
  wire [1:0] sub4 = reg_idx[1:0];

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [EN_W-1:0] en_ff [NUM_EN_REGS];
  logic [SEL_W-1:0] sel_ff [NUM_CH];
  logic [MODE_W-1:0] mode_ff [NUM_CH];

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_EN_REGS; i++) begin
        en_ff[i] <= EN_RESET;
      end
    end else if (wr_en && in_en) begin
      en_ff[sub5] <= wr_data[EN_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        sel_ff[c] <= SEL_RESET;
        mode_ff[c] <= MODE_RESET;
      end
    end else if (wr_en && in_sel) begin
      sel_ff[sub4] <= wr_data[SEL_W-1:0];
    end else if (wr_en && in_mode) begin
      mode_ff[sub4] <= wr_data[MODE_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Routing
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0] en_flat;
  logic [NUM_SRC-1:0] claim_acc [NUM_CH+1];
  logic [NUM_SRC-1:0] claimed_mask;
  logic [NUM_CH-1:0] nxt_dma_req;
  logic [NUM_CH-1:0] ch_claim;

  for (genvar i = 0; i < NUM_EN_REGS; i++) begin : g_en
    assign en_flat[i*EN_W +: EN_W] = en_ff[i];
  end

  assign claim_acc[0] = '0;
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign ch_claim[c] = ch_claims(mode_ff[c]);
    // Out-of-range selector picks nothing rather than aliasing
    assign nxt_dma_req[c] = sel_ok(sel_ff[c]) ? irq_src[sel_ff[c]] : 1'b0;
    assign claim_acc[c+1] = claim_acc[c] |
      ((ch_claim[c] && sel_ok(sel_ff[c])) ? (NUM_SRC'(1) << sel_ff[c]) : '0);
  end
  assign claimed_mask = claim_acc[NUM_CH];

  wire [NUM_SRC-1:0] free_src = irq_src & ~claimed_mask;
  wire [NUM_SRC-1:0] nxt_blk = free_src & en_flat;
  wire [NUM_SRC-1:0] nxt_cpu = free_src & ~en_flat;

  logic [NUM_CH-1:0] dma_req_ff;
  logic [NUM_SRC-1:0] blk_xfer_req_ff;
  logic [NUM_SRC-1:0] cpu_irq_req_ff;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dma_req_ff <= '0;
      blk_xfer_req_ff <= '0;
      cpu_irq_req_ff <= '0;
    end else begin
      dma_req_ff <= nxt_dma_req;
      blk_xfer_req_ff <= nxt_blk;
      cpu_irq_req_ff <= nxt_cpu;
    end
  end

  assign dma_req = dma_req_ff;
  assign blk_xfer_req = blk_xfer_req_ff;
  assign cpu_irq_req = cpu_irq_req_ff;

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  // Claim words let software see which sources the DMA side holds
  assign rd_data = in_en ? {16'h0000, en_ff[sub5]} :
                   in_sel ? {25'h0, sel_ff[sub4]} :
                   in_mode ? {28'h0, mode_ff[sub4]} :
                   in_claim ? {16'h0000, claimed_mask[{sub5, 4'h0} +: EN_W]} :
                   32'h0000_0000;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_mux_ch0: assert property (
    ##1 dma_req[0] == $past(sel_ok(sel_ff[0]) && irq_src[sel_ff[0]]))
    else $error("channel 0 request does not follow selected source");
  a_claim_needs_cond: assert property (
    (ch_claim == '0) |-> (claimed_mask == '0))
    else $error("source claimed without a qualifying channel");
  a_claim_exact: assert property (
    (mode_ff[0] == 4'hd && sel_ok(sel_ff[0])) |-> claimed_mask[sel_ff[0]])
    else $error("qualified channel 0 did not claim its source");
  a_claim_no_blk: assert property (
    1'b1 |=> ((blk_xfer_req & $past(claimed_mask)) == '0))
    else $error("claimed source reached transfer unit");
  a_claim_no_cpu: assert property (
    1'b1 |=> ((cpu_irq_req & $past(claimed_mask)) == '0))
    else $error("claimed source reached cpu");
  a_route_exclusive: assert property (
    (blk_xfer_req & cpu_irq_req) == '0)
    else $error("source routed to both consumers");
  a_en_write: assert property (
    (wr_en && reg_idx == IDX_EN_BASE) |=> en_ff[0] == $past(wr_data[EN_W-1:0]))
    else $error("enable register A write lost");
  a_route_split: assert property (
    1'b1 |=> ((blk_xfer_req | cpu_irq_req) == $past(irq_src & ~claimed_mask)) &&
             ((blk_xfer_req & ~$past(en_flat)) == '0))
    else $error("unclaimed source misrouted");

  c_claimed: cover property (claimed_mask != '0 && irq_src[sel_ff[0]]);
  c_blk: cover property (blk_xfer_req != '0);
  c_cpu: cover property (cpu_irq_req != '0);
  c_read: cover property (!hreadyout ##1 hreadyout);

endmodule

`default_nettype wire

// ==== common/activation_router_pkg.sv ====
// Behaviour
// - Per-channel selector muxes one source to DMA
// - Claim needs kind 1/0, enable, claim bit
// - Claimed sources never reach transfer unit/CPU
// - Unclaimed sources steered by per-source enable
// - Five enable registers A to E
`default_nettype none

package activation_router_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 80;
  localparam int NUM_CH = 4;
  localparam int SEL_W = 7;
  localparam int NUM_EN_REGS = 5;
  localparam int EN_W = 16;
  localparam int MODE_W = 4;

  // ----------------------------------------------------------------
  // Register word indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_EN_BASE = 6'h00;
  localparam logic [5:0] IDX_SEL_BASE = 6'h08;
  localparam logic [5:0] IDX_MODE_BASE = 6'h0c;
  localparam logic [5:0] IDX_CLAIM_BASE = 6'h10;
  localparam logic [5:0] IDX_SPAN4 = 6'h04;
  localparam logic [5:0] IDX_SPAN5 = 6'h05;

  // ----------------------------------------------------------------
  // Channel mode control fields
  // ----------------------------------------------------------------
  localparam int MODE_CLAIM_BIT = 0;
  localparam int MODE_KIND_LO_BIT = 1;
  localparam int MODE_KIND_HI_BIT = 2;
  localparam int MODE_ENABLE_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [EN_W-1:0] EN_RESET = 16'h0000;
  localparam logic [SEL_W-1:0] SEL_RESET = 7'h00;
  localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Bus slave phases
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WRITE = 2'b01,
    PH_RDWAIT = 2'b10
  } phase_type;

endpackage

`default_nettype wire

// ==== rtl/router_ahb_slave.sv ====
`timescale 1ns/1ps
`default_nettype none

module router_ahb_slave
  import activation_router_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic wr_en,
  output logic [5:0] reg_idx,
  output logic [31:0] wr_data,
  input wire logic [31:0] rd_data
);

  phase_type phase_ff;
  phase_type nxt_phase;
  logic [5:0] idx_ff;
  logic [31:0] hrdata_ff;
  wire addr_ok;

  // ----------------------------------------------------------------
  // Address phase decode
  // ----------------------------------------------------------------
  // Only whole-word singles are issued, so hsize is not checked
  assign addr_ok = hsel & htrans[1] & hready;
  assign nxt_phase = (phase_ff == PH_RDWAIT) ? PH_IDLE :
                     !addr_ok ? PH_IDLE :
                     hwrite ? PH_WRITE : PH_RDWAIT;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      phase_ff <= PH_IDLE;
      idx_ff <= 6'h00;
    end else begin
      phase_ff <= nxt_phase;
      if (addr_ok && phase_ff != PH_RDWAIT) begin
        idx_ff <= haddr[7:2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Data phase
  // ----------------------------------------------------------------
  // One wait state on reads keeps hrdata registered
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (phase_ff == PH_RDWAIT) begin
      hrdata_ff <= rd_data;
    end
  end

  assign hreadyout = (phase_ff != PH_RDWAIT);
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign wr_en = (phase_ff == PH_WRITE);
  assign reg_idx = idx_ff;
  assign wr_data = hwdata;

endmodule

`default_nettype wire

// ==== bench/consumer_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module consumer_model
  import activation_router_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [NUM_CH-1:0] dma_req,
  input wire logic [NUM_SRC-1:0] blk_xfer_req,
  input wire logic [NUM_SRC-1:0] cpu_irq_req,
  output logic [15:0] busy_cycles_ff
);
  // Observe only: the consumers take level requests and never push back
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      busy_cycles_ff <= 16'h0000;
    end else if (|{dma_req, blk_xfer_req, cpu_irq_req}) begin
      busy_cycles_ff <= busy_cycles_ff + 16'h0001;
    end
  end
endmodule

`default_nettype wire

// ==== bench/interrupt_activation_router_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module interrupt_activation_router_tb_top
  import activation_router_pkg::*;
;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [NUM_SRC-1:0] irq_src = {NUM_SRC{1'b0}};
  wire logic hreadyout;
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic [NUM_CH-1:0] dma_req;
  wire logic [NUM_SRC-1:0] blk_xfer_req;
  wire logic [NUM_SRC-1:0] cpu_irq_req;
  wire logic [15:0] busy;
  int mismatches = 0;
  int compares = 0;
  logic [31:0] rd;
  logic [3:0] modes [6] = '{4'hd, 4'hc, 4'hf, 4'h9, 4'h5, 4'hd};

  interrupt_activation_router u_interrupt_activation_router (.core_clk(core_clk), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq_src(irq_src),
    .dma_req(dma_req), .blk_xfer_req(blk_xfer_req), .cpu_irq_req(cpu_irq_req));
  consumer_model u_consumer_model (.core_clk(core_clk), .nrst(nrst), .dma_req(dma_req),
    .blk_xfer_req(blk_xfer_req), .cpu_irq_req(cpu_irq_req), .busy_cycles_ff(busy));

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus master
  // ----------------------------------------------------------------
  // Values read right after the edge are the ones sampled at it
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      end_sim();
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic rdchk(input string name, input logic [5:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(name, rd, exp);
  endtask

  // Single source high, then let the one-cycle routing latency settle
  task automatic fire(input int n);
    logic [NUM_SRC-1:0] v;
    v = {NUM_SRC{1'b0}};
    v[n] = 1'b1;
    irq_src <= v;
    repeat (3) @(posedge core_clk);
  endtask

  initial begin
    int c;
    int n;
    logic clm;
    logic en;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rdchk("en_a", IDX_EN_BASE, 32'h0);
    rdchk("sel0", IDX_SEL_BASE, 32'h0);
    rdchk("mode0", IDX_MODE_BASE, 32'h0);
    bus(1'b1, 6'h20, 32'hffff_ffff);
    rdchk("unmapped", 6'h20, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    fire(5);
    chk("cpu5", {31'h0, cpu_irq_req[5]}, 32'h1);
    chk("blk5", {31'h0, blk_xfer_req[5]}, 32'h0);
    for (int r = 0; r < NUM_EN_REGS; r++) begin
      bus(1'b1, IDX_EN_BASE + 6'(r), 32'h1 << r);
      rdchk("en", IDX_EN_BASE + 6'(r), 32'h1 << r);
      fire(r * 17);
      chk("blk_en", {31'h0, blk_xfer_req[r * 17]}, 32'h1);
      chk("cpu_en", {31'h0, cpu_irq_req[r * 17]}, 32'h0);
      fire(r * 17 + 1);
      chk("cpu_nb", {31'h0, cpu_irq_req[r * 17 + 1]}, 32'h1);
    end
    // Alternate the enable so withholding is seen against both consumers
    for (int i = 0; i < 6; i++) begin
      c = i % NUM_CH;
      n = 64 + i;
      clm = (modes[i] == 4'hd);
      en = (i % 2 == 0);
      bus(1'b1, IDX_EN_BASE + 6'h04, en ? 32'h00ff : 32'h0);
      bus(1'b1, IDX_SEL_BASE + 6'(c), 32'(n));
      bus(1'b1, IDX_MODE_BASE + 6'(c), {28'h0, modes[i]});
      rdchk("mode", IDX_MODE_BASE + 6'(c), {28'h0, modes[i]});
      fire(n);
      chk("dma", {28'h0, dma_req}, 32'h1 << c);
      chk("blk", {31'h0, blk_xfer_req[n]}, {31'h0, !clm && en});
      chk("cpu", {31'h0, cpu_irq_req[n]}, {31'h0, !clm && !en});
      rdchk("claimed", IDX_CLAIM_BASE + 6'h04, clm ? 32'h1 << i : 32'h0);
      bus(1'b1, IDX_MODE_BASE + 6'(c), 32'h0);
    end
    bus(1'b1, IDX_SEL_BASE, 32'h50);
    bus(1'b1, IDX_MODE_BASE, 32'hd);
    fire(64);
    chk("dma_none", {28'h0, dma_req}, 32'h0);
    chk("partner", {31'h0, busy != 16'h0}, 32'h1);
    end_sim();
  end
endmodule

`default_nettype wire
